// ===== tmsc_status_ctrl.v
// Purpose: status flags, alert latch, configuration, rate and limit
//          registers of a two-channel temperature monitor
// Assumes: byte-level serial slave front end on the same clock; ADC
//          results valid on i_local_temp/i_remote_temp/i_remote_open
// Notes:   the alert pin is open drain, driven low when o_alert_oen low
`timescale 1ns/1ps
`include "tmsc_regs.vh"

// Contract
// - status bit 7 is one exactly while a conversion runs
// - status bits 6..3 flag local/remote high and low limit trips
// - status bit 2 flags an open remote sensor
// - any set flag sets the alert latch, pulling alert low
// - status read clears only flags whose cause has gone
// - flag stays while its comparator trips or sensor stays open
// - latch clears only on alert-response read, errors gone, flags clear
// - flags stay high until a status read or power-on reset
// - config bit 6: zero runs conversions, one selects standby
// - low standby pin forces standby regardless of config
// - temperature values are held through standby
// - config bit 7 masks the alert output when one
// - rate low three bits divide clock, 0x07 125 ms, 0x00 16 s
// - rate register is writable and readable by the host
// - four host read/write limit registers exist
// - high trips on strictly greater, low on strictly less
// - negative limit values are accepted
// - one-shot write in standby runs one conversion then standby
// - one-shot data byte is ignored and not stored
// - device acts only as a bus slave
// - separate read and write addresses; wrong direction reads invalid
// - any data byte written to address 0F triggers a one-shot; a pointer-only write does not
// - first write byte loads the address pointer
// - alert response read answers when alert latch is set
module tmsc_status_ctrl #(
    parameter [31:0] P_PERIOD_CYC = `TMSC_PERIOD_CYC,
    parameter [31:0] P_CONV_CYC = `TMSC_CONV_CYC,
    parameter [7:0] P_DEV_ID = 8'h5A, // arbitrary value
    parameter [7:0] P_REV_ID = 8'h01 // arbitrary value
) (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_standby_pin_n,
    input wire i_wr_valid,
    input wire i_wr_first,
    input wire [7:0] i_wr_data,
    input wire i_rd_req,
    input wire i_ara_req,
    input wire [7:0] i_local_temp,
    input wire [7:0] i_remote_temp,
    input wire i_remote_open,
    output reg [7:0] o_rd_data,
    output reg o_rd_valid,
    output reg o_ara_valid,
    output reg o_ara_hit,
    output reg o_alert_out,
    output reg o_alert_oen,
    output wire o_conv_busy
);

////////////////////////////////////////////////////////////////////////
// declarations
reg [2:0] standby_pin_n_sync_q;
reg standby_pin_n_q;
reg [7:0] ptr_q;
reg [7:0] config_q;
reg [7:0] rate_q;
reg [7:0] loc_hi_q;
reg [7:0] loc_lo_q;
reg [7:0] rem_hi_q;
reg [7:0] rem_lo_q;
reg [7:0] local_val_q;
reg [7:0] remote_val_q;
reg [4:0] flags_q;
reg [4:0] cond_q;
reg alert_latch_q;
reg oneshot_q;
wire conv_done;
wire run_mode;
wire data_wr;
wire status_rd;
wire local_over_flag;
wire local_under_flag;
wire remote_over_flag;
wire remote_under_flag;
wire [4:0] cond_new;
wire [4:0] flag_set;
wire [4:0] flag_keep;
wire [4:0] flags_d;
wire alert_mask_bit;
reg [7:0] rd_mux;
wire [15:0] chan_temp;
wire [15:0] chan_hi;
wire [15:0] chan_lo;
wire [1:0] chan_over;
wire [1:0] chan_under;
genvar g;

assign data_wr = i_wr_valid && !i_wr_first;
assign status_rd = i_rd_req && (ptr_q == `TMSC_RD_STATUS);
assign alert_mask_bit = config_q[`TMSC_CFG_MASK];

////////////////////////////////////////////////////////////////////////
// standby pin: three flops, accept a level once stages two/three agree
// a one-cycle glitch on the pin is filtered out before the timer
always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        standby_pin_n_sync_q <= 3'h7;
        standby_pin_n_q <= 1'b1;
    end else if (i_ce) begin
        standby_pin_n_sync_q <= {standby_pin_n_sync_q[1:0], i_standby_pin_n};
        if (standby_pin_n_sync_q[1] == standby_pin_n_sync_q[2]) begin
            standby_pin_n_q <= standby_pin_n_sync_q[2];
        end
    end
end

// either config or pin puts the converter to sleep
assign run_mode = !config_q[`TMSC_CFG_STANDBY] &&
                  standby_pin_n_q;

////////////////////////////////////////////////////////////////////////
// conversion pacing
// the timer owns busy, so status bit 7 needs no copy of its own
tmsc_conv_timer #(
    .P_PERIOD_CYC(P_PERIOD_CYC),
    .P_CONV_CYC(P_CONV_CYC)
) u_timer (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_run(run_mode),
    .i_oneshot(oneshot_q),
    .i_rate(rate_q[2:0]),
    .o_busy(o_conv_busy),
    .o_done(conv_done)
);

////////////////////////////////////////////////////////////////////////
// host writes; only this slave port changes state from outside
// the pointer survives reads, so repeated polls need no pointer byte
always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        ptr_q <= 8'h00;
        config_q <= `TMSC_RST_CONFIG;
        rate_q <= `TMSC_RST_RATE;
        loc_hi_q <= `TMSC_RST_LIM_HI;
        loc_lo_q <= `TMSC_RST_LIM_LO;
        rem_hi_q <= `TMSC_RST_LIM_HI;
        rem_lo_q <= `TMSC_RST_LIM_LO;
        oneshot_q <= 1'b0;
    end else if (i_ce) begin
        oneshot_q <= 1'b0;
        if (i_wr_valid && i_wr_first) begin
            ptr_q <= i_wr_data;
        end
        if (data_wr) begin
            case (ptr_q)
                `TMSC_WR_CONFIG: begin
                    // reserved bits 5..0 are kept at zero
                    config_q <= {i_wr_data[7:6], 6'h00};
                end
                `TMSC_WR_RATE: rate_q <= i_wr_data;
                // limits stored as raw signed bytes, negatives allowed
                `TMSC_WR_LOC_HI: loc_hi_q <= i_wr_data;
                `TMSC_WR_LOC_LO: loc_lo_q <= i_wr_data;
                `TMSC_WR_REM_HI: rem_hi_q <= i_wr_data;
                `TMSC_WR_REM_LO: rem_lo_q <= i_wr_data;
                // data byte discarded, the write itself is the trigger
                `TMSC_WR_ONESHOT: oneshot_q <= 1'b1;
                default: oneshot_q <= 1'b0; // read-only addresses ignored
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// value registers load only at conversion end, so standby holds them
always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        local_val_q <= `TMSC_RST_TEMP;
        remote_val_q <= `TMSC_RST_TEMP;
    end else if (i_ce && conv_done) begin
        local_val_q <= i_local_temp;
        remote_val_q <= i_remote_temp;
    end
end

////////////////////////////////////////////////////////////////////////
// limit compare on the fresh result, signed so negative limits work;
// index 1 carries the local channel, index 0 the remote one
assign chan_temp = {i_local_temp, i_remote_temp};
assign chan_hi = {loc_hi_q, rem_hi_q};
assign chan_lo = {loc_lo_q, rem_lo_q};

// one strict comparator pair per channel
generate
    for (g = 0; g < 2; g = g + 1) begin : g_chan
        assign chan_over[g] = $signed(chan_temp[8*g +: 8]) >
                              $signed(chan_hi[8*g +: 8]);
        assign chan_under[g] = $signed(chan_temp[8*g +: 8]) <
                               $signed(chan_lo[8*g +: 8]);
    end
endgenerate

// flag names in status order
assign local_over_flag = chan_over[1];
assign local_under_flag = chan_under[1];
assign remote_over_flag = chan_over[0];
assign remote_under_flag = chan_under[0];
assign cond_new = {local_over_flag, local_under_flag,
                   remote_over_flag, remote_under_flag,
                   i_remote_open};

// a flag sets only on a conversion end that sees its condition
assign flag_set = conv_done ? cond_new : 5'h00;
// a status read keeps flags whose cause is still standing
assign flag_keep = status_rd ? (flags_q & cond_q) : flags_q;
// set wins over a clear landing in the same cycle
assign flags_d = flag_keep | flag_set;

always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        flags_q <= 5'h00;
        cond_q <= 5'h00;
    end else if (i_ce) begin
        flags_q <= flags_d;
        if (conv_done) begin
            cond_q <= cond_new;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// alert latch: status reads never touch it; alert response may clear
// limitation: a masked part still answers the alert response, since
// the hit follows the latch and not the pin; keep it clear when shared
always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        alert_latch_q <= 1'b0;
        o_ara_valid <= 1'b0;
        o_ara_hit <= 1'b0;
    end else if (i_ce) begin
        o_ara_valid <= i_ara_req;
        o_ara_hit <= i_ara_req && alert_latch_q;
        if (|flags_d) begin
            alert_latch_q <= 1'b1;
        end else if (i_ara_req && alert_latch_q && !(|cond_q)) begin
            alert_latch_q <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// open-drain pin; mask releases the pin but leaves the latch alone
// data held low, only the enable moves: it never fights the pull-up
always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        o_alert_out <= 1'b0;
        o_alert_oen <= 1'b1;
    end else if (i_ce) begin
        o_alert_out <= 1'b0;
        o_alert_oen <= !(alert_latch_q && !alert_mask_bit);
    end
end

////////////////////////////////////////////////////////////////////////
// read mux; write-only and unmapped addresses give the invalid byte
// reserved status bits 1..0 always read as zero
always @* begin
    case (ptr_q)
        `TMSC_RD_LOCAL_VAL: rd_mux = local_val_q;
        `TMSC_RD_REMOTE_VAL: rd_mux = remote_val_q;
        `TMSC_RD_STATUS: rd_mux = {o_conv_busy, flags_q, 2'h0};
        `TMSC_RD_CONFIG: rd_mux = config_q;
        `TMSC_RD_RATE: rd_mux = rate_q;
        `TMSC_RD_LOC_HI: rd_mux = loc_hi_q;
        `TMSC_RD_LOC_LO: rd_mux = loc_lo_q;
        `TMSC_RD_REM_HI: rd_mux = rem_hi_q;
        `TMSC_RD_REM_LO: rd_mux = rem_lo_q;
        `TMSC_RD_DEV_ID: rd_mux = P_DEV_ID;
        `TMSC_RD_REV_ID: rd_mux = P_REV_ID;
        default: rd_mux = `TMSC_INVALID_RD;
    endcase
end

// read byte registered; pointer is left where it was
always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        o_rd_data <= 8'h00;
        o_rd_valid <= 1'b0;
    end else if (i_ce) begin
        o_rd_valid <= i_rd_req;
        if (i_rd_req) begin
            o_rd_data <= rd_mux;
        end
    end
end

endmodule // tmsc_status_ctrl

// ===== tmsc_regs.vh
// Purpose: register map, field positions, reset values and timing counts
//          of the temperature monitor status/control block
// Assumes: 200 MHz reference clock
// Notes:   definitions only
`ifndef TMSC_REGS_VH
`define TMSC_REGS_VH

// read addresses
`define TMSC_RD_LOCAL_VAL   8'h00
`define TMSC_RD_REMOTE_VAL  8'h01
`define TMSC_RD_STATUS      8'h02
`define TMSC_RD_CONFIG      8'h03
`define TMSC_RD_RATE        8'h04
`define TMSC_RD_LOC_HI      8'h05
`define TMSC_RD_LOC_LO      8'h06
`define TMSC_RD_REM_HI      8'h07
`define TMSC_RD_REM_LO      8'h08
`define TMSC_RD_DEV_ID      8'hFE
`define TMSC_RD_REV_ID      8'hFF

// write addresses
`define TMSC_WR_CONFIG      8'h09
`define TMSC_WR_RATE        8'h0A
`define TMSC_WR_LOC_HI      8'h0B
`define TMSC_WR_LOC_LO      8'h0C
`define TMSC_WR_REM_HI      8'h0D
`define TMSC_WR_REM_LO      8'h0E
`define TMSC_WR_ONESHOT     8'h0F

// status fields
`define TMSC_ST_BUSY        7
`define TMSC_ST_FLAG_MSB    6
`define TMSC_ST_FLAG_LSB    2

// configuration fields
`define TMSC_CFG_MASK       7
`define TMSC_CFG_STANDBY    6

// reset values
`define TMSC_RST_CONFIG     8'h00
`define TMSC_RST_RATE       8'h02
`define TMSC_RST_TEMP       8'h80
`define TMSC_RST_LIM_HI     8'h7F
`define TMSC_RST_LIM_LO     8'hC9
`define TMSC_INVALID_RD     8'hFF

// rate field and timing
`define TMSC_RATE_FASTEST   3'h7
`define TMSC_CLK_KHZ        200000
`define TMSC_PERIOD_MIN_MS  125
`define TMSC_PERIOD_CYC     (`TMSC_PERIOD_MIN_MS * `TMSC_CLK_KHZ)
`define TMSC_CONV_MS        10
`define TMSC_CONV_CYC       (`TMSC_CONV_MS * `TMSC_CLK_KHZ)

`endif

// ===== tmsc_conv_timer.v
// Purpose: paces conversions from the rate code, runs one-shots
// Assumes: i_oneshot is a one-cycle pulse on the same clock
// Notes:   o_busy and o_done come straight from flip-flops
`timescale 1ns/1ps
`include "tmsc_regs.vh"

module tmsc_conv_timer #(
    parameter [31:0] P_PERIOD_CYC = `TMSC_PERIOD_CYC,
    parameter [31:0] P_CONV_CYC = `TMSC_CONV_CYC
) (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_run,
    input wire i_oneshot,
    input wire [2:0] i_rate,
    output reg o_busy,
    output reg o_done
);

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_CONV = 2'h1;
localparam [1:0] ST_WAIT = 2'h2;

reg [1:0] state_q;
reg [31:0] cnt_q;
wire [2:0] shift_amt;
wire [31:0] period_cyc;

// slowest code divides by 128, 16 s at code 0
assign shift_amt = `TMSC_RATE_FASTEST - i_rate;
assign period_cyc = P_PERIOD_CYC << shift_amt;

////////////////////////////////////////////////////////////////////////
// conversion sequencer
always @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        state_q <= ST_IDLE;
        cnt_q <= 32'h0;
        o_busy <= 1'b0;
        o_done <= 1'b0;
    end else if (i_ce) begin
        o_done <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                // one-shot only matters in standby; running starts anyway
                if (i_run || i_oneshot) begin
                    state_q <= ST_CONV;
                    cnt_q <= 32'h0;
                    o_busy <= 1'b1;
                end
            end
            ST_CONV: begin
                cnt_q <= cnt_q + 32'h1;
                if (cnt_q == P_CONV_CYC - 32'h1) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    // a one-shot falls back to standby after one conversion
                    state_q <= i_run ? ST_WAIT : ST_IDLE;
                end
            end
            ST_WAIT: begin
                cnt_q <= cnt_q + 32'h1;
                if (!i_run) begin
                    state_q <= ST_IDLE;
                end else if (cnt_q >= period_cyc - 32'h1) begin
                    state_q <= ST_CONV;
                    cnt_q <= 32'h0;
                    o_busy <= 1'b1;
                end
            end
            default: begin
                state_q <= ST_IDLE;
                o_busy <= 1'b0;
            end
        endcase
    end
end

endmodule // tmsc_conv_timer

// ===== tmsc_status_ctrl_asserts.sv
// Purpose: port checks of the status/control block
// Assumes: one clock, async active-low reset
// Notes:   bound onto every instance of the block
`timescale 1ns/1ps
//////////////////////////////
module tmsc_status_ctrl_asserts (
    input wire i_ref_clk,
    input wire i_rstn,
    input wire i_ce,
    input wire i_wr_valid,
    input wire i_rd_req,
    input wire i_ara_req,
    input wire [7:0] o_rd_data,
    input wire o_rd_valid,
    input wire o_ara_valid,
    input wire o_ara_hit,
    input wire o_alert_oen,
    input wire o_conv_busy
);
    // loose bound: bench conversions are far shorter
    localparam int BUSY_MAX = 64;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // read and alert-response answers
    AST_RD_ANSWER: assert property (
        i_ce && i_rd_req |=> o_rd_valid) else $error("read unanswered");
    AST_RD_ONLY: assert property (
        o_rd_valid |-> $past(i_rd_req)) else $error("unasked read");
    AST_RD_HOLD: assert property (
        !o_rd_valid |-> $stable(o_rd_data)) else $error("read data moved");
    AST_ARA_ANSWER: assert property (
        i_ce && i_ara_req |=> o_ara_valid) else $error("ara unanswered");
    AST_HIT_QUAL: assert property (
        o_ara_hit |-> o_ara_valid) else $error("hit without valid");
    // a pulled pin means a set latch, so the device must answer
    AST_HIT_PIN: assert property (
        o_ara_valid && !$past(o_alert_oen) && !$past(i_ara_req, 2)
        |-> o_ara_hit) else $error("alert low but no hit");
    // pin is freed only by alert service or a mask write
    AST_OEN_RISE: assert property (
        $rose(o_alert_oen) |-> $past(o_ara_hit)
        || $past(i_wr_valid) || $past(i_wr_valid, 2))
        else $error("alert freed unserviced");
    AST_BUSY_END: assert property (
        $rose(o_conv_busy) |-> ##[1:BUSY_MAX] !o_conv_busy)
        else $error("conversion never ends");
endmodule // tmsc_status_ctrl_asserts
//////////////////////////////
bind tmsc_status_ctrl tmsc_status_ctrl_asserts u_chk (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_wr_valid(i_wr_valid), .i_rd_req(i_rd_req),
    .i_ara_req(i_ara_req), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_ara_valid(o_ara_valid),
    .o_ara_hit(o_ara_hit), .o_alert_oen(o_alert_oen),
    .o_conv_busy(o_conv_busy));

// ===== tmsc_host_model.sv
// Purpose: byte-level bus host master that services alerts
// Assumes: requests move on the falling clock edge
// Notes:   freed write data shows the inverse of its last value
`timescale 1ns/1ps
//////////////////////////////
module tmsc_host_model (
    input wire i_clk,
    input wire [7:0] i_rd_data,
    input wire i_rd_valid,
    input wire i_ara_valid,
    input wire i_ara_hit,
    output reg o_wr_valid,
    output reg o_wr_first,
    output reg [7:0] o_wr_data,
    output reg o_rd_req,
    output reg o_ara_req
);
    // idle bus; all traffic starts here, the device only answers
    initial begin
        o_wr_valid = 1'b0;
        o_wr_first = 1'b0;
        o_wr_data = 8'hA5;
        o_rd_req = 1'b0;
        o_ara_req = 1'b0;
    end
    // pointer byte, then an optional data byte
    task wr(input [7:0] p, input den, input [7:0] d);
        begin
            @(negedge i_clk);
            o_wr_valid = 1'b1;
            o_wr_first = 1'b1;
            o_wr_data = p;
            if (den) begin
                @(negedge i_clk);
                o_wr_first = 1'b0;
                o_wr_data = (p == 8'h0A) ? (d & 8'h07) : d;
            end
            @(negedge i_clk);
            o_wr_valid = 1'b0;
            o_wr_data = ~o_wr_data;
        end
    endtask
    // one byte read at the pointer
    task rd(output [7:0] d, output v);
        begin
            @(negedge i_clk);
            o_rd_req = 1'b1;
            @(negedge i_clk);
            d = i_rd_data;
            v = i_rd_valid;
            o_rd_req = 1'b0;
        end
    endtask
    // alert response read; hit means the device answered
    task ara(output h, output v);
        begin
            @(negedge i_clk);
            o_ara_req = 1'b1;
            @(negedge i_clk);
            h = i_ara_hit;
            v = i_ara_valid;
            o_ara_req = 1'b0;
        end
    endtask
endmodule // tmsc_host_model

// ===== tmsc_status_ctrl_tb.sv
// Purpose: self-checking bench of the status/control block
// Assumes: period cut to 40 and conversion to 8 cycles
// Notes:   sensor inputs move only between conversions
`timescale 1ns/1ps
//////////////////////////////
module tmsc_status_ctrl_tb;
    localparam [31:0] PER = 32'h28;
    reg clk, rstn, standby_pin_n_n, ropen, v, h;
    reg [7:0] ltemp, rtemp, d;
    integer err_total, checks, n, i, t0, cyc;
    wire wr_valid, wr_first, rd_req, ara_req, rd_valid, ara_valid;
    wire ara_hit, alert_oen, alert_out, busy;
    wire [7:0] wr_data, rd_data;
    tmsc_status_ctrl #(.P_PERIOD_CYC(PER), .P_CONV_CYC(32'h8)) u_dut (
        .i_ref_clk(clk), .i_rstn(rstn), .i_ce(1'b1),
        .i_standby_pin_n(standby_pin_n_n), .i_wr_valid(wr_valid),
        .i_wr_first(wr_first), .i_wr_data(wr_data), .i_rd_req(rd_req),
        .i_ara_req(ara_req), .i_local_temp(ltemp), .i_remote_temp(rtemp),
        .i_remote_open(ropen), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .o_ara_valid(ara_valid), .o_ara_hit(ara_hit),
        .o_alert_out(alert_out),
        .o_alert_oen(alert_oen), .o_conv_busy(busy));
    tmsc_host_model u_host (
        .i_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
        .i_ara_valid(ara_valid), .i_ara_hit(ara_hit),
        .o_wr_valid(wr_valid), .o_wr_first(wr_first),
        .o_wr_data(wr_data), .o_rd_req(rd_req), .o_ara_req(ara_req));
    //////////////////////////////
    // byte and count compares; unknowns never match
    task chk8(input [7:0] got, input [7:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("Error %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task chkn(input integer got, input integer exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("Error %0t: count %0d want %0d", $time, got, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", checks, err_total);
            if (err_total == 0 && checks > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    // bounded wait for a busy level
    task wait_busy(input b);
        begin
            n = 0;
            while (busy !== b && n < 20000) begin
                @(negedge clk);
                n = n + 1;
            end
            if (n == 20000) begin
                err_total = err_total + 1;
                $display("Error %0t: busy wait ran out", $time);
                stop_test;
            end
        end
    endtask
    task conv;
        begin
            wait_busy(1'b1);
            wait_busy(1'b0);
            repeat (2) @(negedge clk);
        end
    endtask
    task rdp(input [7:0] p, input [7:0] m, input [7:0] e);
        begin
            u_host.wr(p, 1'b0, 8'h00);
            u_host.rd(d, v);
            chk8({7'h00, v}, 8'h01);
            chk8(d & m, e);
        end
    endtask
    task idle_chk;
        for (i = 0; i < 60; i = i + 1) begin
            @(negedge clk);
            chk8({7'h00, busy}, 8'h00);
        end
    endtask
    //////////////////////////////
    task t_regs;
        reg [63:0] adr, exp;
        begin
            adr = 64'h03040506_0708090F;
            exp = 64'h00027FC9_7FC9FFFF;
            for (i = 0; i < 8; i = i + 1) begin
                rdp(adr[63-8*i -: 8], 8'hFF, exp[63-8*i -: 8]);
            end
            u_host.wr(8'h0A, 1'b1, 8'h05);
            rdp(8'h04, 8'hFF, 8'h05);
            exp = 64'h32EC3214_00000000;
            for (i = 0; i < 4; i = i + 1) begin
                u_host.wr(8'h0B + i[7:0], 1'b1, exp[63-8*i -: 8]);
                rdp(8'h05 + i[7:0], 8'hFF, exp[63-8*i -: 8]);
            end
            u_host.wr(8'h0A, 1'b1, 8'h07);
            $display("t_regs done");
        end
    endtask
    task t_flags;
        begin
            conv;
            ltemp = 8'h32;
            conv;
            rdp(8'h02, 8'h7F, 8'h00);
            {ltemp, rtemp, ropen} = {8'h33, 8'h13, 1'b1};
            conv;
            {ltemp, rtemp, ropen} = {8'h14, 8'h14, 1'b0};
            rdp(8'h02, 8'h7F, 8'h4C);
            chk8({7'h00, alert_oen}, 8'h00);
            rdp(8'h02, 8'h7F, 8'h4C);
            conv;
            rdp(8'h02, 8'h7F, 8'h4C);
            rdp(8'h02, 8'h7F, 8'h00);
            chk8({7'h00, alert_oen}, 8'h00);
            u_host.ara(h, v);
            chk8({6'h00, v, h}, 8'h03);
            @(negedge clk);
            chk8({7'h00, alert_oen}, 8'h01);
            u_host.ara(h, v);
            chk8({6'h00, v, h}, 8'h02);
            $display("t_flags done");
        end
    endtask
    task t_mask;
        begin
            u_host.wr(8'h09, 1'b1, 8'h80);
            conv;
            // local reading below a negative limit, remote one above
            {ltemp, rtemp} = 16'hEB33;
            conv;
            {ltemp, rtemp} = 16'h1414;
            chk8({7'h00, alert_oen}, 8'h01);
            rdp(8'h02, 8'h7F, 8'h30);
            u_host.wr(8'h09, 1'b1, 8'h00);
            @(negedge clk);
            chk8({7'h00, alert_oen}, 8'h00);
            u_host.ara(h, v);
            @(negedge clk);
            chk8({5'h00, alert_oen, v, h}, 8'h03);
            conv;
            rdp(8'h02, 8'h7F, 8'h30);
            u_host.ara(h, v);
            @(negedge clk);
            chk8({5'h00, alert_oen, v, h}, 8'h07);
            $display("t_mask done");
        end
    endtask
    task t_standby;
        begin
            u_host.wr(8'h09, 1'b1, 8'h40);
            repeat (2) @(negedge clk);
            wait_busy(1'b0);
            repeat (2) @(negedge clk);
            ltemp = 8'h0A;
            idle_chk;
            rdp(8'h00, 8'hFF, 8'h14);
            u_host.wr(8'h0F, 1'b1, 8'hAA);
            conv;
            rdp(8'h00, 8'hFF, 8'h0A);
            idle_chk;
            rdp(8'h03, 8'hFF, 8'h40);
            standby_pin_n_n = 1'b0;
            repeat (4) @(negedge clk);
            u_host.wr(8'h09, 1'b1, 8'h00);
            idle_chk;
            standby_pin_n_n = 1'b1;
            wait_busy(1'b1);
            $display("t_standby done");
        end
    endtask
    // period between conversion starts for every rate code
    task t_rate;
        integer code;
        for (code = 7; code >= 0; code = code - 1) begin
            u_host.wr(8'h0A, 1'b1, code[7:0]);
            conv;
            wait_busy(1'b1);
            t0 = cyc;
            wait_busy(1'b0);
            wait_busy(1'b1);
            chkn(cyc - t0, PER << (7 - code));
        end
    endtask
    // flags, latch and rate fall to a power-on reset in mid-run
    task t_por;
        begin
            u_host.wr(8'h0A, 1'b1, 8'h07);
            conv;
            ltemp = 8'h33;
            conv;
            ltemp = 8'h14;
            chk8({6'h00, alert_out, alert_oen}, 8'h00);
            rstn = 1'b0;
            repeat (16) @(negedge clk);
            rstn = 1'b1;
            chk8({7'h00, alert_oen}, 8'h01);
            rdp(8'h02, 8'h7F, 8'h00);
            rdp(8'h04, 8'hFF, 8'h02);
            $display("t_por done");
        end
    endtask
    //////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk) cyc <= cyc + 1;
    initial begin
        {rstn, standby_pin_n_n, ropen, ltemp, rtemp} = {2'b01, 1'b0, 16'h1414};
        err_total = 0;
        checks = 0;
        cyc = 0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        t_regs;
        t_flags;
        t_mask;
        t_standby;
        t_rate;
        $display("t_rate done");
        t_por;
        stop_test;
    end
endmodule // tmsc_status_ctrl_tb
